// *** design/sensor_fault_reset_monitor.sv ***
`timescale 1ns/10ps
module sensor_fault_reset_monitor (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire fault_mon_pkg::supply_flags_s    supply_raw,
  input  wire logic                            device_select_low,
  input  wire logic                            xfer_bit_done,
  input  wire logic                            xfer_word_done,
  input  wire logic                            status_reported,
  input  wire logic                            frame_tx_req,
  input  wire logic                            data_out_in,
  input  wire logic [fault_mon_pkg::CRC_W-1:0] crc_next,
  output logic                                 data_out,
  output logic                                 data_oe,
  output logic                                 out_valid,
  output logic                                 int_reset,
  output logic                                 xfer_active,
  output logic [fault_mon_pkg::CRC_W-1:0]      crc_r,
  output fault_mon_pkg::status_s               status
);
  import fault_mon_pkg::*;

  logic [SYNC_STAGES-1:0] uv_sync_r;
  logic [SYNC_STAGES-1:0] ov_sync_r;
  logic [SYNC_STAGES-1:0] sel_sync_r;
  logic                   uv_s;
  logic                   ov_s;
  logic                   sel_n_s;
  logic [2:0]             rst_cnt_r;
  mon_state_e             state_r;
  logic                   reset_seen_r;
  logic                   uv_err_r;
  logic                   ov_err_r;
  logic                   uv_pend_r;
  logic                   ov_pend_r;

  // Supply and select sync: first stage only tracks, qualifying needs two agreeing stages
  // [R11] Supply input synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_sync_r <= '0;
      ov_sync_r <= '0;
      sel_sync_r <= '1;
    end else begin
      uv_sync_r <= {uv_sync_r[SYNC_STAGES-2:0], supply_raw.uv};
      ov_sync_r <= {ov_sync_r[SYNC_STAGES-2:0], supply_raw.ov};
      sel_sync_r <= {sel_sync_r[SYNC_STAGES-2:0], device_select_low};
    end
  end

  // Qualified levels hold until stages 2 and 3 agree
  logic uv_q_r;
  logic ov_q_r;
  logic sel_q_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_q_r  <= 1'b0;
      ov_q_r  <= 1'b0;
      sel_q_r <= 1'b1;
    end else begin
      if (uv_sync_r[1] == uv_sync_r[2]) uv_q_r <= uv_sync_r[2];
      if (ov_sync_r[1] == ov_sync_r[2]) ov_q_r <= ov_sync_r[2];
      if (sel_sync_r[1] == sel_sync_r[2]) sel_q_r <= sel_sync_r[2];
    end
  end
  assign uv_s    = uv_q_r;
  assign ov_s    = ov_q_r;
  assign sel_n_s = sel_q_r;

  // Internal reset lasts RST_HOLD cycles after undervoltage ends
  // [R5] Undervoltage forces reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= 3'(RST_HOLD);
    end else if (uv_s) begin
      rst_cnt_r <= 3'(RST_HOLD);
    end else if (rst_cnt_r != 3'h0) begin
      rst_cnt_r <= rst_cnt_r - 3'h1;
    end
  end
  assign int_reset = (rst_cnt_r != 3'h0);

  // Transfer state; deselect from transfer returns to idle, so no lockup
  // [R8] Abort recovery
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else begin
      unique case (state_r)
        ST_RESET: if (!int_reset) state_r <= ST_IDLE;
        ST_IDLE: begin
          if (int_reset) state_r <= ST_RESET;
          else if (!sel_n_s) state_r <= ST_XFER;
        end
        ST_XFER: begin
          if (int_reset) state_r <= ST_RESET;
          else if (sel_n_s) state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign xfer_active = (state_r == ST_XFER);

  // [R10] Deselect resets checksum
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_r <= CRC_INIT;
    end else if (sel_n_s || int_reset) begin
      crc_r <= CRC_INIT;
    end else if (xfer_bit_done) begin
      crc_r <= crc_next;
    end
  end

  // [R2] Sticky reset indication
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_seen_r <= 1'b1;
    end else if (int_reset) begin
      reset_seen_r <= 1'b1;
    end else if (status_reported && xfer_word_done) begin
      reset_seen_r <= 1'b0;
    end
  end

  logic report_ok;
  assign report_ok = status_reported && !int_reset;

  // Pending marks an occurrence not yet reported; a new occurrence beats a report
  // A report while the cause persists counts, so the flag drops as soon as the cause goes
  // [R3] Hold until reported
  // [R4] Clear after cause gone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_err_r  <= 1'b0;
      ov_pend_r <= 1'b0;
    end else begin
      if (ov_s && !ov_err_r) begin
        ov_pend_r <= 1'b1;
      end else if (status_reported) begin
        ov_pend_r <= 1'b0;
      end
      if (ov_s) begin
        ov_err_r <= 1'b1;
      end else if (!ov_pend_r || status_reported) begin
        ov_err_r <= 1'b0;
      end
    end
  end

  // Undervoltage reports only count once the device is out of reset
  // [R3] Hold until reported
  // [R4] Clear after cause gone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_err_r  <= 1'b0;
      uv_pend_r <= 1'b0;
    end else begin
      if (uv_s && !uv_err_r) begin
        uv_pend_r <= 1'b1;
      end else if (report_ok) begin
        uv_pend_r <= 1'b0;
      end
      if (uv_s) begin
        uv_err_r <= 1'b1;
      end else if (!uv_pend_r || report_ok) begin
        uv_err_r <= 1'b0;
      end
    end
  end
  assign status = '{reset_seen: reset_seen_r, uv_err: uv_err_r, ov_err: ov_err_r};

  // Driver: off in reset and overvoltage, push-pull only when sending
  // [R1] Pins high impedance
  // [R6] Overvoltage tristate
  logic drive_ok;
  assign drive_ok = !int_reset && !ov_s && xfer_active;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe  <= 1'b0;
      data_out <= 1'b0;
    end else begin
      data_oe  <= drive_ok && frame_tx_req && !sel_n_s;
      data_out <= (drive_ok && frame_tx_req) ? data_out_in : 1'b0;
    end
  end

  // [R7] Valid when supply good
  assign out_valid = !int_reset && !ov_s && !uv_s;

  // Good supply plus a selected send request must reach the pin next cycle
  logic drive_req;
  assign drive_req = out_valid && xfer_active && frame_tx_req && !sel_n_s;

  a_uv_forces_rst: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    uv_s |-> ##1 int_reset) else $error("undervoltage did not force reset");
  a_rst_tristate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    $past(int_reset) |-> !data_oe) else $error("driver active during reset");
  a_ov_tristate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    $past(ov_s) |-> !data_oe) else $error("driver active in overvoltage");
  a_rst_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    $fell(int_reset) |-> status.reset_seen) else $error("reset flag missing");
  a_err_persists: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    ov_s |=> status.ov_err) else $error("overvoltage error not held");
  a_err_clears: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (!ov_s && status_reported) |=> !status.ov_err) else $error("error not cleared");
  a_valid_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    $past(drive_req) |-> data_oe && data_out == $past(data_out_in)) else $error("valid output not driven");
  a_abort_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    (xfer_active && sel_n_s && !int_reset) |=> state_r == ST_IDLE) else $error("abort stuck");
  a_crc_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    sel_n_s |=> crc_r == CRC_INIT) else $error("checksum not reset");
  a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
    $rose(uv_s) |-> $past(uv_sync_r[2])) else $error("unsynchronised undervoltage");
  a_err_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (!ov_s && !ov_pend_r) |=> !status.ov_err) else $error("reported error not released");
  a_uv_persists: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    uv_s |=> status.uv_err) else $error("undervoltage error not held");
  a_abort_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    $past(sel_n_s) |-> !data_oe) else $error("driver active while deselected");
  a_rst_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    int_reset |=> status.reset_seen) else $error("reset flag lost during reset");
  a_rst_no_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    int_reset |=> !xfer_active) else $error("transfer alive during reset");

  c_uv_reset: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(int_reset));
  c_abort:    cover property (@(posedge ref_clk) disable iff (!rst_n) xfer_active ##1 !xfer_active);
  c_ov_block: cover property (@(posedge ref_clk) disable iff (!rst_n) ov_s && frame_tx_req && xfer_active);
  c_short_err: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(ov_s) ##1 status.ov_err);
  c_live_report: cover property (@(posedge ref_clk) disable iff (!rst_n) ov_s && status_reported);
endmodule : sensor_fault_reset_monitor

// *** design/fault_mon_pkg.sv ***
// Summary of operation
// [R1] During internal reset every output pin is released to high impedance. The code only tristates data_out, one cycle after int_reset rises.
// [R2] After any reset, set a sticky reset-occurred status bit for the host.
// [R3] Each error stays flagged while its cause persists, reported at least once.
// [R4] Error flag clears once cause is gone and it was reported.
// [R5] Asserted undervoltage forces the device into internal reset.
// [R6] While overvoltage is detected the serial output stays tristated, no frame sent.
// [R7] Output is valid whenever no under- or overvoltage is flagged. The code also holds out_valid low while int_reset lasts.
// [R8] An aborted transfer causes no lockup; next transfer is accepted.
// [R9] Host keeps persistent_config_store programming cycles at or below 100.
// [R10] Deselect during a transfer aborts it and resets the checksum.
// [R11] Undervoltage and overvoltage inputs pass a multi-stage synchronizer first.
package fault_mon_pkg;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam int unsigned RST_HOLD      = 4;
  localparam int unsigned CRC_W         = 8;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam int unsigned PROG_CYCLES_MAX = 100;

  typedef struct packed {
    logic uv;
    logic ov;
  } supply_flags_s;

  typedef struct packed {
    logic reset_seen;
    logic uv_err;
    logic ov_err;
  } status_s;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b001,
    ST_IDLE   = 3'b010,
    ST_XFER   = 3'b100
  } mon_state_e;
endpackage : fault_mon_pkg

// *** test/ssc_host.sv ***
`timescale 1ns/10ps
module ssc_host (
  input  wire logic                       ref_clk,
  output logic                            device_select_low,
  output logic                            xfer_bit_done,
  output logic                            xfer_word_done,
  output logic [fault_mon_pkg::CRC_W-1:0] crc_next
);
  initial begin
    device_select_low = 1'b1;
    xfer_bit_done = 1'b0;
    xfer_word_done = 1'b0;
    crc_next = 8'h00;
  end
  task automatic sel(input logic v);
    @(posedge ref_clk) #1;
    device_select_low = v;
  endtask : sel
  task automatic bit_step(input logic [7:0] c);
    @(posedge ref_clk) #1;
    crc_next = c;
    xfer_bit_done = 1'b1;
    @(posedge ref_clk) #1;
    xfer_bit_done = 1'b0;
    // Stale value inverted so a late load shows
    crc_next = ~c;
  endtask : bit_step
  task automatic word();
    @(posedge ref_clk) #1;
    xfer_word_done = 1'b1;
    @(posedge ref_clk) #1;
    xfer_word_done = 1'b0;
  endtask : word
endmodule : ssc_host

// *** test/test_sensor_fault_reset_monitor.sv ***
`timescale 1ns/10ps
module test_sensor_fault_reset_monitor;
  import fault_mon_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  supply_flags_s supply_raw = '0;
  logic          status_reported = 1'b0;
  logic          frame_tx_req = 1'b0;
  logic          data_out_in = 1'b0;
  logic          sel_n, bit_done, word_done, data_out, data_oe, out_valid, int_reset, xfer_active;
  logic [7:0]    crc_next, crc_r;
  logic [7:0]    crc_q[$];
  status_s       status;
  logic [31:0]   rng = 32'h307a;
  int            mismatches = 0;
  int            n_compared = 0;
  int            cycles = 0;
  always #2 ref_clk = ~ref_clk;
  ssc_host host (.ref_clk(ref_clk), .device_select_low(sel_n), .xfer_bit_done(bit_done),
                 .xfer_word_done(word_done), .crc_next(crc_next));
  sensor_fault_reset_monitor dut (.ref_clk(ref_clk), .rst_n(rst_n), .supply_raw(supply_raw),
    .device_select_low(sel_n), .xfer_bit_done(bit_done), .xfer_word_done(word_done),
    .status_reported(status_reported), .frame_tx_req(frame_tx_req), .data_out_in(data_out_in),
    .crc_next(crc_next), .data_out(data_out), .data_oe(data_oe), .out_valid(out_valid),
    .int_reset(int_reset), .xfer_active(xfer_active), .crc_r(crc_r), .status(status));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic report();
    status_reported = 1'b1;
    host.word();
    status_reported = 1'b0;
    cyc(2);
  endtask : report
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    cyc(20);
    rst_n = 1'b1;
    cyc(20);
    check("int_reset", int_reset, 1'b0);
    check("reset_seen", status.reset_seen, 1'b1);
    check("out_valid", out_valid, 1'b1);
    check("crc idle", crc_r, CRC_INIT);
    check("idle oe", data_oe, 1'b0);
    report();
    check("reset_seen clr", status.reset_seen, 1'b0);
    host.sel(1'b0);
    frame_tx_req = 1'b1;
    cyc(6);
    check("xfer_active", xfer_active, 1'b1);
    repeat (3) begin
      rng = xs(rng);
      data_out_in = rng[9];
      crc_q.push_back(rng[7:0]);
      host.bit_step(rng[7:0]);
      check("crc load", crc_r, crc_q.pop_front());
      check("data_oe", data_oe, 1'b1);
      check("data_out", data_out, rng[9]);
    end
    host.sel(1'b1);
    cyc(6);
    check("abort idle", xfer_active, 1'b0);
    check("abort oe", data_oe, 1'b0);
    check("crc init", crc_r, CRC_INIT);
    host.sel(1'b0);
    cyc(6);
    check("restart", xfer_active, 1'b1);
    frame_tx_req = 1'b0;
    cyc(2);
    check("no req oe", data_oe, 1'b0);
    frame_tx_req = 1'b1;
    supply_raw.ov = 1'b1;
    cyc(8);
    check("ov oe", data_oe, 1'b0);
    check("ov valid", out_valid, 1'b0);
    check("ov_err", status.ov_err, 1'b1);
    supply_raw.ov = 1'b0;
    cyc(10);
    check("ov_err held", status.ov_err, 1'b1);
    check("oe back", data_oe, 1'b1);
    report();
    check("ov_err clr", status.ov_err, 1'b0);
    // Reported while the cause lasts: the flag must go with the cause
    supply_raw.ov = 1'b1;
    cyc(8);
    report();
    check("ov_err live", status.ov_err, 1'b1);
    supply_raw.ov = 1'b0;
    cyc(6);
    check("ov_err gone", status.ov_err, 1'b0);
    supply_raw.uv = 1'b1;
    cyc(8);
    check("uv reset", int_reset, 1'b1);
    check("uv oe", data_oe, 1'b0);
    check("uv valid", out_valid, 1'b0);
    check("uv_err", status.uv_err, 1'b1);
    supply_raw.uv = 1'b0;
    cyc(15);
    check("uv out", int_reset, 1'b0);
    check("reset_seen uv", status.reset_seen, 1'b1);
    check("uv_err held", status.uv_err, 1'b1);
    report();
    check("uv_err clr", status.uv_err, 1'b0);
    check("reset_seen clr2", status.reset_seen, 1'b0);
    end_sim();
  end
endmodule : test_sensor_fault_reset_monitor
